// ===== hdl/energy_channel_select_and_averaging_cfg.sv
`timescale 1ns/1ps
`include "energy_sel_defs.svh"
module energy_channel_select_and_averaging_cfg (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // Register access from serial engine
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [5:0]  regAddr,
  input  wire logic [23:0] regWrData,
  output logic      [23:0] regRdData,
  output logic             regRdValid,
  // Configuration bits
  input  wire logic        fixedVoltageEnable,
  input  wire logic        lineCycleMode,
  input  wire logic        selectByCurrent,
  // Timing strobes
  input  wire logic        owrTick,
  input  wire logic        halfCycleTick,
  input  wire logic        startCmd,
  // Channel results
  input  wire logic        avgValid,
  input  wire logic [23:0] firstChannelAvgPower,
  input  wire logic [23:0] secondChannelAvgPower,
  input  wire logic [23:0] firstChannelRmsCurrent,
  input  wire logic [23:0] secondChannelRmsCurrent,
  // Summed powers and voltage
  input  wire logic        sumValid,
  input  wire logic [23:0] summedActivePower,
  input  wire logic [23:0] summedReactivePower,
  input  wire logic [23:0] summedApparentPower,
  input  wire logic [23:0] measuredVoltageRms,
  // Results
  output logic             chanSel,
  output logic [23:0]      activeOut,
  output logic [23:0]      reactiveOut,
  output logic [23:0]      apparentOut,
  output logic [23:0]      voltageRmsUsed,
  output logic             settling,
  output logic             windowDone
);

  // ==========================================
  // Register file
  logic [23:0] hyst_ff, samples_ff, selMin_ff;
  logic [23:0] settle_ff, noLoad_ff, vfixRef_ff, halfCyc_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      hyst_ff    <= `RST_HYST;
      samples_ff <= `RST_SAMPLES;
      selMin_ff  <= `RST_SEL_MIN;
      settle_ff  <= `RST_SETTLE;
      noLoad_ff  <= `RST_NOLOAD;
      vfixRef_ff <= `RST_FIXED_VOLTAGE_ENABLE_REF;
      halfCyc_ff <= `RST_HALFCYC;
    end else if (regWrEn) begin
      unique case (regAddr)
        `ADDR_HYST:     hyst_ff    <= regWrData;
        `ADDR_SAMPLES:  samples_ff <= regWrData;
        `ADDR_SEL_MIN:  selMin_ff  <= regWrData;
        `ADDR_SETTLE:   settle_ff  <= regWrData;
        `ADDR_NOLOAD:   noLoad_ff  <= regWrData;
        `ADDR_FIXED_VOLTAGE_ENABLE_REF: vfixRef_ff <= regWrData;
        `ADDR_HALFCYC:  halfCyc_ff <= regWrData;
        default: ;
      endcase
    end
  end

  logic [23:0] regRdData_ff;
  logic        regRdValid_ff;

  // Unmapped indices read as zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      regRdData_ff  <= `CNT_ZERO;
      regRdValid_ff <= 1'b0;
    end else begin
      regRdValid_ff <= regRdEn;
      if (regRdEn) begin
        unique case (regAddr)
          `ADDR_HYST:     regRdData_ff <= hyst_ff;
          `ADDR_SAMPLES:  regRdData_ff <= samples_ff;
          `ADDR_SEL_MIN:  regRdData_ff <= selMin_ff;
          `ADDR_SETTLE:   regRdData_ff <= settle_ff;
          `ADDR_NOLOAD:   regRdData_ff <= noLoad_ff;
          `ADDR_FIXED_VOLTAGE_ENABLE_REF: regRdData_ff <= vfixRef_ff;
          `ADDR_HALFCYC:  regRdData_ff <= halfCyc_ff;
          default:        regRdData_ff <= `CNT_ZERO;
        endcase
      end
    end
  end

  assign regRdData  = regRdData_ff;
  assign regRdValid = regRdValid_ff;

  // ==========================================
  // Automatic channel selection
  logic signed [23:0] valA, valB, bigVal, smallVal;
  logic [23:0]        hystEff;
  logic signed [48:0] hystProd, bigScaled;
  logic               bWins, passHyst, passMin;
  logic               chanSel_ff;

  always_comb begin
    valA = selectByCurrent ? firstChannelRmsCurrent : firstChannelAvgPower;
    valB = selectByCurrent ? secondChannelRmsCurrent : secondChannelAvgPower;
    bWins = valB > valA;
    bigVal = bWins ? valB : valA;
    smallVal = bWins ? valA : valB;
    // Unity or less collapses to a plain compare
    hystEff = (hyst_ff <= `HYST_UNITY) ? `HYST_UNITY : hyst_ff;
    // Unsigned Q1.23 times signed Q1.23 keeps 46 fraction bits
    hystProd = smallVal * $signed({1'b0, hystEff});
    bigScaled = 49'(bigVal) <<< `HYST_FRAC_BITS;
    passHyst = bigScaled > hystProd;
    passMin = bigVal > $signed(selMin_ff);
  end

  // Choice held unless both tests pass on a fresh result
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      chanSel_ff <= 1'b0;
    end else if (avgValid && passHyst && passMin) begin
      chanSel_ff <= bWins;
    end
  end

  assign chanSel = chanSel_ff;

  // ==========================================
  // Anti-creep on summed powers
  logic [24:0] magP, magQ, magS, thrExt;
  logic        pqQuiet, sQuiet;
  logic [23:0] activeOut_ff, reactiveOut_ff, apparentOut_ff;

  function automatic logic [24:0] absVal(input logic [23:0] v);
    logic [24:0] ext;
    ext = {v[23], v};
    absVal = v[23] ? 25'(-$signed(ext)) : ext;
  endfunction : absVal

  always_comb begin
    magP = absVal(summedActivePower);
    magQ = absVal(summedReactivePower);
    magS = absVal(summedApparentPower);
    // Negative threshold treated as zero so nothing is masked
    thrExt = noLoad_ff[23] ? {1'b0, `CNT_ZERO} : {1'b0, noLoad_ff};
    pqQuiet = (magP < thrExt) && (magQ < thrExt);
    sQuiet = magS < thrExt;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      activeOut_ff   <= `CNT_ZERO;
      reactiveOut_ff <= `CNT_ZERO;
      apparentOut_ff <= `CNT_ZERO;
    end else if (sumValid) begin
      activeOut_ff   <= pqQuiet ? `CNT_ZERO : summedActivePower;
      reactiveOut_ff <= pqQuiet ? `CNT_ZERO : summedReactivePower;
      apparentOut_ff <= sQuiet ? `CNT_ZERO : summedApparentPower;
    end
  end

  assign activeOut   = activeOut_ff;
  assign reactiveOut = reactiveOut_ff;
  assign apparentOut = apparentOut_ff;

  // ==========================================
  // Voltage RMS source for energy accumulation
  logic [23:0] vUsed_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vUsed_ff <= `CNT_ZERO;
    end else begin
      vUsed_ff <= fixedVoltageEnable ? vfixRef_ff : measuredVoltageRms;
    end
  end

  assign voltageRmsUsed = vUsed_ff;

  // ==========================================
  // Settling and averaging window sequencer
  energy_sel_pkg::phase_e phase_ff;
  logic [23:0] cnt_ff;
  logic        done_ff;
  logic        winTick;
  logic [23:0] winLen;

  always_comb begin
    winTick = lineCycleMode ? halfCycleTick : owrTick;
    winLen = lineCycleMode ? halfCyc_ff : samples_ff;
  end

  // A start command restarts settling from any phase
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_ff <= energy_sel_pkg::ST_IDLE;
      cnt_ff   <= `CNT_ZERO;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (startCmd) begin
        phase_ff <= energy_sel_pkg::ST_SETTLE;
        cnt_ff   <= `CNT_ZERO;
      end else begin
        unique case (phase_ff)
          energy_sel_pkg::ST_IDLE: ;
          energy_sel_pkg::ST_SETTLE: begin
            // Zero settle count falls straight through
            if (cnt_ff >= settle_ff) begin
              phase_ff <= energy_sel_pkg::ST_AVG;
              cnt_ff   <= `CNT_ZERO;
            end else if (owrTick) begin
              cnt_ff <= cnt_ff + `CNT_ONE;
            end
          end
          energy_sel_pkg::ST_AVG: begin
            if (winTick) begin
              // Zero length is outside the legal range; behaves as one
              if (cnt_ff + `CNT_ONE >= winLen) begin
                cnt_ff  <= `CNT_ZERO;
                done_ff <= 1'b1;
              end else begin
                cnt_ff <= cnt_ff + `CNT_ONE;
              end
            end
          end
          default: phase_ff <= energy_sel_pkg::ST_IDLE;
        endcase
      end
    end
  end

  assign settling   = (phase_ff == energy_sel_pkg::ST_SETTLE);
  assign windowDone = done_ff;

  // ==========================================
  // Checks
  hyst_reset_a: assert property (@(posedge mclk) $fell(rst) |-> hyst_ff == `RST_HYST)
    else $error("hysteresis reset value wrong");

  sel_hold_a: assert property (@(posedge mclk) disable iff (rst)
    (avgValid && !passHyst) |=> $stable(chanSel))
    else $error("channel changed without hysteresis margin");

  sel_min_a: assert property (@(posedge mclk) disable iff (rst)
    (avgValid && bigVal <= $signed(selMin_ff)) |=> chanSel == $past(chanSel))
    else $error("channel changed below minimum");

  sel_take_a: assert property (@(posedge mclk) disable iff (rst)
    (avgValid && passHyst && passMin) |=> chanSel == $past(bWins))
    else $error("larger channel not selected");

  hyst_unity_a: assert property (@(posedge mclk) disable iff (rst)
    (hyst_ff <= `HYST_UNITY) |-> (passHyst == (bigVal > smallVal)))
    else $error("hysteresis applied at or below unity");

  creep_pq_a: assert property (@(posedge mclk) disable iff (rst)
    (sumValid && pqQuiet) |=> (activeOut == `CNT_ZERO && reactiveOut == `CNT_ZERO))
    else $error("active or reactive not zeroed");

  creep_s_a: assert property (@(posedge mclk) disable iff (rst)
    (sumValid && !sQuiet) |=> apparentOut == $past(summedApparentPower))
    else $error("apparent power wrongly zeroed");

  // Compared with the reference as sampled, so a rewrite while enabled is legal
  fixed_voltage_enable_use_a: assert property (@(posedge mclk) disable iff (rst)
    fixedVoltageEnable |=> voltageRmsUsed == $past(vfixRef_ff))
    else $error("fixed reference not used");

  settle_exit_a: assert property (@(posedge mclk) disable iff (rst)
    (phase_ff == energy_sel_pkg::ST_SETTLE && !startCmd && cnt_ff < settle_ff) |=>
    phase_ff != energy_sel_pkg::ST_AVG)
    else $error("settling ended early");

  window_cnt_a: assert property (@(posedge mclk) disable iff (rst)
    windowDone |-> $past(winTick) && ($past(cnt_ff) + `CNT_ONE >= $past(winLen)))
    else $error("window ended at wrong count");

endmodule : energy_channel_select_and_averaging_cfg

// ===== hdl/energy_sel_defs.svh
`ifndef ENERGY_SEL_DEFS_SVH
`define ENERGY_SEL_DEFS_SVH
// ==========================================
// Register indices
`define ADDR_HYST      6'h32
`define ADDR_SAMPLES   6'h33
`define ADDR_SEL_MIN   6'h38
`define ADDR_SETTLE    6'h39
`define ADDR_NOLOAD    6'h3A
`define ADDR_FIXED_VOLTAGE_ENABLE_REF  6'h3B
`define ADDR_HALFCYC   6'h3E
// ==========================================
// Reset values
`define RST_HYST       24'h828F5C
`define RST_SAMPLES    24'h000FA0
`define RST_SEL_MIN    24'h00624D
`define RST_SETTLE     24'h00001E
`define RST_NOLOAD     24'h000000
`define RST_FIXED_VOLTAGE_ENABLE_REF   24'h5A8279
`define RST_HALFCYC    24'h000064
// ==========================================
// Fixed-point constants
`define HYST_UNITY     24'h800000
`define HYST_FRAC_BITS 23
`define CNT_ONE        24'h000001
`define CNT_ZERO       24'h000000
`endif

// ===== hdl/energy_sel_pkg.sv
package energy_sel_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h1,
    ST_SETTLE = 3'h2,
    ST_AVG    = 3'h4
  } phase_e;
endpackage : energy_sel_pkg

// ===== bench/tb_energy_channel_select_and_averaging_cfg.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, b); end end
module tb_energy_channel_select_and_averaging_cfg;
  // ==========================================
  // Signals and model state
  logic mclk, rst, regWrEn, regRdEn, regRdValid, chanSel, settling, windowDone;
  logic fixedVoltageEnable, lineCycleMode, selectByCurrent;
  logic owrTick, halfCycleTick, startCmd, avgValid, sumValid, chanExp;
  logic [5:0] regAddr;
  logic [23:0] regWrData, regRdData, p1, p2, i1, i2, sp, sq, ss, vm;
  logic [23:0] activeOut, reactiveOut, apparentOut, voltageRmsUsed;
  logic [23:0] hyst, selMin, thr, vref, actExp, reaExp, appExp, vExp;
  logic [31:0] rnd;
  int err_count = 0;
  int checks = 0;
  logic [5:0] addrs [7] = '{6'h32, 6'h33, 6'h38, 6'h39, 6'h3A, 6'h3B, 6'h3E};
  logic [23:0] rstv [7] = '{24'h828F5C, 24'h000FA0, 24'h00624D, 24'h00001E, 24'h000000, 24'h5A8279, 24'h000064};

  energy_channel_select_and_averaging_cfg dut (
    .mclk, .rst, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .regRdValid,
    .fixedVoltageEnable, .lineCycleMode, .selectByCurrent, .owrTick, .halfCycleTick, .startCmd,
    .avgValid, .firstChannelAvgPower(p1), .secondChannelAvgPower(p2),
    .firstChannelRmsCurrent(i1), .secondChannelRmsCurrent(i2), .sumValid,
    .summedActivePower(sp), .summedReactivePower(sq), .summedApparentPower(ss),
    .measuredVoltageRms(vm), .chanSel, .activeOut, .reactiveOut, .apparentOut,
    .voltageRmsUsed, .settling, .windowDone
  );

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ==========================================
  // Helpers
  function automatic logic [23:0] rand24();
    repeat (7) rnd = rnd[0] ? (rnd >> 1) ^ 32'h80200003 : rnd >> 1;
    return rnd[23:0];
  endfunction : rand24

  function automatic longint mag(input logic [23:0] v);
    longint s = longint'($signed(v));
    return (s < 0) ? -s : s;
  endfunction : mag

  // Exact product, so no rounding can hide a hysteresis slip
  function automatic logic pick(input logic [23:0] a, input logic [23:0] b, input logic prev);
    longint x = longint'($signed(a));
    longint y = longint'($signed(b));
    longint h = (hyst > 24'h800000) ? hyst : 24'h800000;
    longint m = longint'($signed(selMin));
    if (y > x && y * 8388608 > h * x && y > m)
      return 1'b1;
    if (x > y && x * 8388608 > h * y && x > m)
      return 1'b0;
    return prev;
  endfunction : pick

  task automatic tick();
    @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    tick();
    regWrEn = 1'b0;
    // Idle cycle so a following write never re-raises the strobe at once
    tick();
  endtask : wr

  task automatic rd(input logic [5:0] a, input logic [23:0] d);
    regRdEn = 1'b1;
    regAddr = a;
    tick();
    regRdEn = 1'b0;
    `CHK(regRdValid, 1'b1)
    `CHK(regRdData, d)
    tick();
  endtask : rd

  task automatic cfg(input logic [23:0] h, input logic [23:0] m, input logic [23:0] t, input logic [23:0] v);
    hyst = h;
    selMin = m;
    thr = t;
    vref = v;
    wr(6'h32, h);
    wr(6'h38, m);
    wr(6'h3A, t);
    wr(6'h3B, v);
  endtask : cfg

  // ==========================================
  // Random traffic on selection, anti-creep and voltage source
  task automatic randRun(input int n);
    logic z;
    repeat (n) begin
      {avgValid, sumValid, fixedVoltageEnable, selectByCurrent} = 4'(rand24());
      p1 = rand24() >> 1;
      p2 = rand24() >> 1;
      i1 = rand24() >> 1;
      i2 = rand24() >> 1;
      sp = $signed(rand24()) >>> 3;
      sq = $signed(rand24()) >>> 3;
      ss = $signed(rand24()) >>> 3;
      vm = rand24();
      if (avgValid)
        chanExp = selectByCurrent ? pick(i1, i2, chanExp) : pick(p1, p2, chanExp);
      if (sumValid) begin
        z = mag(sp) < mag(thr) && mag(sq) < mag(thr);
        actExp = z ? 24'h000000 : sp;
        reaExp = z ? 24'h000000 : sq;
        appExp = (mag(ss) < mag(thr)) ? 24'h000000 : ss;
      end
      vExp = fixedVoltageEnable ? vref : vm;
      tick();
      `CHK(chanSel, chanExp)
      `CHK(activeOut, actExp)
      `CHK(reactiveOut, reaExp)
      `CHK(apparentOut, appExp)
      `CHK(voltageRmsUsed, vExp)
    end
    // Strobes low so later register writes cannot move results behind the model
    {avgValid, sumValid} = 2'b00;
  endtask : randRun

  // ==========================================
  // Settling then windowed averaging
  task automatic seqRun(input int n, input int s, input int w, input logic lm);
    logic st, hit, stExp;
    int sCnt, wCnt;
    wr(6'h39, 24'(s));
    wr(lm ? 6'h3E : 6'h33, 24'(w));
    lineCycleMode = lm;
    startCmd = 1'b1;
    tick();
    startCmd = 1'b0;
    sCnt = 0;
    wCnt = 0;
    `CHK(settling, 1'b1)
    repeat (n) begin
      {owrTick, halfCycleTick} = 2'(rand24());
      st = settling;
      // Settling ends one cycle after the last counted sample
      stExp = st && sCnt < s;
      hit = !st && (lm ? halfCycleTick : owrTick);
      sCnt += int'(stExp && owrTick);
      wCnt += int'(hit);
      tick();
      `CHK(settling, stExp)
      `CHK(windowDone, hit && wCnt % w == 0)
    end
    {owrTick, halfCycleTick} = 2'b00;
  endtask : seqRun

  task automatic results();
    $display("checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : results

  initial begin
    rnd = 32'h0000002E;
    {regWrEn, regRdEn, regAddr, regWrData, fixedVoltageEnable, lineCycleMode, selectByCurrent} = '0;
    {owrTick, halfCycleTick, startCmd, avgValid, sumValid, p1, p2, i1, i2, sp, sq, ss, vm} = '0;
    {chanExp, actExp, reaExp, appExp} = '0;
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 1'b0;
    for (int k = 0; k < 7; k++)
      rd(addrs[k], rstv[k]);
    rd(6'h00, 24'h000000);
    for (int k = 0; k < 7; k++) begin
      wr(addrs[k], rstv[k] ^ 24'h3C3C3C);
      rd(addrs[k], rstv[k] ^ 24'h3C3C3C);
    end
    cfg(24'h828F5C, 24'h00624D, 24'h000000, 24'h5A8279);
    randRun(150);
    cfg(24'h800000, 24'h400000, 24'h040000, 24'h123456);
    randRun(150);
    cfg(24'h400000, 24'h00624D, 24'h100000, 24'h7FFFFF);
    randRun(150);
    cfg(24'hFFFFFF, 24'h000000, 24'h020000, 24'h000001);
    randRun(150);
    seqRun(300, 3, 100, 1'b0);
    seqRun(120, 0, 1, 1'b1);
    seqRun(200, 5, 3, 1'b1);
    results();
  end

  // Tests take about 1300 cycles; twelve thousand is ample
  initial begin
    #100000;
    err_count++;
    results();
  end
endmodule : tb_energy_channel_select_and_averaging_cfg
